// ---- logic/ard_decoder.sv ----
// aperture decoder steering top-of-aperture dwords onto register ports
`timescale 1ns/100ps
`include "ard_regs.svh"
module ard_decoder
	import ard_pkg::*;
#(
	parameter int AW = 22
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic mm_reg_en,
	input wire logic ap_4mb,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [AW-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_be,
	input wire logic fb_rvalid,
	input wire logic [31:0] fb_rdata,
	input wire logic reg_rvalid,
	input wire logic [15:0] reg_rdata,
	output logic fb_req,
	output logic fb_write,
	output logic [AW-1:0] fb_addr,
	output logic [31:0] fb_wdata,
	output logic [3:0] fb_be,
	output logic reg_rd,
	output logic reg_wr,
	output logic reg_ext,
	output logic [15:0] reg_port,
	output logic [15:0] reg_wdata,
	output logic [1:0] reg_be,
	output logic rsp_valid,
	output logic [31:0] rsp_data
);
	// ************************************************************
	// window decode
	// ************************************************************
	logic [AW-1:0] win_base;
	logic win_hit;
	logic reg_take;
	logic reg_wr_take;
	ard_pend_t pend_reg;
	ard_slot_if sif ();

	ard_slot_map u_map (
		.sif(sif)
	);

	always_comb begin
		// 1MB aperture keeps the window at FFE00; 4MB moves it to the very top
		win_base = ap_4mb ? AW'(`ARD_WIN_BASE_4M) : AW'(`ARD_WIN_BASE_1M);
		win_hit = req_addr[AW-1:`ARD_WIN_LSB] == win_base[AW-1:`ARD_WIN_LSB];
		reg_take = req_valid && mm_reg_en && win_hit;
		// a write touching only the reserved half reaches no register
		reg_wr_take = reg_take && req_write && (req_be[1:0] != 2'h0);
		sif.slot = req_addr[`ARD_WIN_LSB-1:`ARD_SLOT_LSB];
	end

	// ************************************************************
	// frame buffer side
	// ************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fb_req <= 1'b0;
			fb_write <= 1'b0;
			fb_addr <= '0;
			fb_wdata <= 32'h00000000;
			fb_be <= 4'h0;
		end else begin
			// video memory under the window is unreachable while mapping is on
			fb_req <= req_valid && !reg_take;
			if (req_valid && !reg_take) begin
				fb_write <= req_write;
				fb_addr <= req_addr;
				fb_wdata <= req_wdata;
				fb_be <= req_be;
			end
		end
	end

	// ************************************************************
	// register side
	// ************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rd <= 1'b0;
			reg_wr <= 1'b0;
			reg_ext <= 1'b0;
			reg_port <= 16'h0000;
			reg_wdata <= 16'h0000;
			reg_be <= 2'h0;
		end else begin
			// separate strobes let a read-only and a write-only register share a port
			reg_rd <= reg_take && !req_write;
			reg_wr <= reg_wr_take;
			if (reg_take) begin
				reg_port <= sif.port;
				reg_ext <= sif.ext;
				reg_wdata <= req_wdata[`ARD_REG_W-1:0];
				reg_be <= req_be[1:0];
			end
		end
	end

	// ************************************************************
	// read return
	// ************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pend_reg <= ARD_PEND_NONE;
		end else if (req_valid && !req_write) begin
			pend_reg <= reg_take ? ARD_PEND_REG : ARD_PEND_FB;
		end else if ((pend_reg == ARD_PEND_REG && reg_rvalid) ||
			(pend_reg == ARD_PEND_FB && fb_rvalid)) begin
			pend_reg <= ARD_PEND_NONE;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 32'h00000000;
		end else begin
			rsp_valid <= (pend_reg == ARD_PEND_REG && reg_rvalid) ||
				(pend_reg == ARD_PEND_FB && fb_rvalid);
			if (pend_reg == ARD_PEND_REG && reg_rvalid) begin
				rsp_data <= {`ARD_RSV_HALF, reg_rdata};
			end else if (pend_reg == ARD_PEND_FB && fb_rvalid) begin
				rsp_data <= fb_rdata;
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	property p_win_read;
		@(posedge mclk) disable iff (rst)
		reg_take && !req_write |=> reg_rd && !reg_wr && !fb_req;
	endproperty
	a_win_read: assert property (p_win_read) else $error("window read not routed to register");

	property p_map_off;
		@(posedge mclk) disable iff (rst)
		req_valid && !mm_reg_en |=> fb_req && !reg_rd && !reg_wr;
	endproperty
	a_map_off: assert property (p_map_off) else $error("mapping off yet register strobed");

	property p_first_slot;
		@(posedge mclk) disable iff (rst)
		reg_take && req_addr[8:2] == 7'h00 |=> reg_port == 16'h02E8 && !reg_ext;
	endproperty
	a_first_slot: assert property (p_first_slot) else $error("first slot port wrong");

	property p_second_slot;
		@(posedge mclk) disable iff (rst)
		reg_take && req_addr[8:2] == 7'h01 |=> reg_port == 16'h06E8;
	endproperty
	a_second_slot: assert property (p_second_slot) else $error("second slot port wrong");

	property p_last_slot;
		@(posedge mclk) disable iff (rst)
		reg_take && req_addr[8:2] == 7'h7F |=> reg_port == 16'hFEEE && reg_ext;
	endproperty
	a_last_slot: assert property (p_last_slot) else $error("last slot port wrong");

	property p_halves;
		@(posedge mclk) disable iff (rst)
		reg_take |=> reg_port[7:0] == (reg_ext ? 8'hEE : 8'hE8) &&
			reg_ext == $past(req_addr[8]);
	endproperty
	a_halves: assert property (p_halves) else $error("slot half maps to wrong set");

	property p_rsp_low_half;
		@(posedge mclk) disable iff (rst)
		pend_reg == ARD_PEND_REG && reg_rvalid |=>
			rsp_valid && rsp_data == {16'h0000, $past(reg_rdata)};
	endproperty
	a_rsp_low_half: assert property (p_rsp_low_half) else $error("register read data misplaced");

	property p_wr_low_half;
		@(posedge mclk) disable iff (rst)
		reg_wr_take |=> reg_wr && !reg_rd && reg_wdata == $past(req_wdata[15:0]);
	endproperty
	a_wr_low_half: assert property (p_wr_low_half) else $error("register write misrouted");

	property p_top_4mb;
		@(posedge mclk) disable iff (rst)
		req_valid && mm_reg_en && ap_4mb && (&req_addr[AW-1:9]) |=> !fb_req;
	endproperty
	a_top_4mb: assert property (p_top_4mb) else $error("4MB top reached video memory");

	property p_rsv_write;
		@(posedge mclk) disable iff (rst)
		reg_take && req_write && req_be[1:0] == 2'h0 |=> !reg_wr && !fb_req;
	endproperty
	a_rsv_write: assert property (p_rsv_write) else $error("reserved half write had effect");

	property p_fb_pass;
		@(posedge mclk) disable iff (rst)
		req_valid && !reg_take |=> fb_req && fb_addr == $past(req_addr) &&
			fb_write == $past(req_write);
	endproperty
	a_fb_pass: assert property (p_fb_pass) else $error("frame buffer access not forwarded");

	property p_rsp_fb;
		@(posedge mclk) disable iff (rst)
		pend_reg == ARD_PEND_FB && fb_rvalid |=> rsp_valid && rsp_data == $past(fb_rdata);
	endproperty
	a_rsp_fb: assert property (p_rsp_fb) else $error("frame buffer read data lost");

	property p_wr_no_rd;
		@(posedge mclk) disable iff (rst)
		reg_take && req_write |=> !reg_rd && !fb_req;
	endproperty
	a_wr_no_rd: assert property (p_wr_no_rd) else $error("register write strobed a read");
endmodule

// ---- logic/ard_regs.svh ----
// constants of the aperture register window decoder
`ifndef ARD_REGS_SVH
`define ARD_REGS_SVH
`define ARD_WIN_SLOTS 128
`define ARD_HALF_SLOTS 64
`define ARD_SLOT_LSB 2
`define ARD_WIN_LSB 9
`define ARD_WIN_BASE_1M 22'h0FFE00
`define ARD_WIN_BASE_4M 22'h3FFE00
`define ARD_COMPAT_PORT_LOW 16'h02E8
`define ARD_EXT_PORT_LOW 16'h02EE
`define ARD_PORT_STEP_LSB 10
`define ARD_REG_W 16
`define ARD_RSV_HALF 16'h0000
`endif

// ---- logic/ard_pkg.sv ----
// types of the aperture register window decoder
package ard_pkg;
	typedef enum logic [1:0] {
		ARD_PEND_NONE,
		ARD_PEND_FB,
		ARD_PEND_REG
	} ard_pend_t;
endpackage

// ---- logic/ard_slot_if.sv ----
// slot index to port number carrier
`timescale 1ns/100ps
interface ard_slot_if;
	logic [6:0] slot;
	logic [15:0] port;
	logic ext;
	modport map (input slot, output port, output ext);
	modport user (output slot, input port, input ext);
endinterface

// ---- logic/ard_slot_map.sv ----
// maps a window slot index onto its register port number
`timescale 1ns/100ps
`include "ard_regs.svh"
module ard_slot_map
	import ard_pkg::*;
(
	ard_slot_if.map sif
);
	// ************************************************************
	// slot to port
	// ************************************************************
	function automatic logic [15:0] ard_port_of(input logic [6:0] slot);
		logic [15:0] low;
		low = slot[6] ? `ARD_EXT_PORT_LOW : `ARD_COMPAT_PORT_LOW;
		// each slot within a half steps the port's upper bits by one
		ard_port_of = {slot[5:0], low[9:0]};
	endfunction

	always_comb begin
		sif.port = ard_port_of(sif.slot);
		sif.ext = sif.slot[6];
	end
endmodule

// ---- tb/ard_resp.sv ----
// far-side responder for frame buffer and register reads
`timescale 1ns/100ps
module ard_resp (
	input wire logic mclk,
	input wire logic fb_req,
	input wire logic fb_write,
	input wire logic [21:0] fb_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_port,
	output logic fb_rvalid,
	output logic [31:0] fb_rdata,
	output logic reg_rvalid,
	output logic [15:0] reg_rdata
);
	// different delays: frame buffer slow, registers prompt
	logic [3:0] fcnt = 4'h0;
	logic [3:0] rcnt = 4'h0;
	logic [31:0] fd = 32'h0;
	logic [15:0] rd = 16'h0;
	initial begin
		fb_rvalid = 1'h0;
		reg_rvalid = 1'h0;
		fb_rdata = 32'h0;
		reg_rdata = 16'h0;
	end
	// idle data lines toggle so stale values never pass
	always @(posedge mclk) begin
		fb_rvalid <= (fcnt == 4'h1);
		reg_rvalid <= (rcnt == 4'h1);
		fcnt <= (fb_req && !fb_write) ? 4'h3 : (fcnt != 4'h0) ? fcnt - 4'h1 : 4'h0;
		rcnt <= reg_rd ? 4'h2 : (rcnt != 4'h0) ? rcnt - 4'h1 : 4'h0;
		if (fb_req)
			fd <= {10'h000, fb_addr};
		if (reg_rd)
			rd <= reg_port;
		fb_rdata <= (fcnt == 4'h1) ? fd : ~fb_rdata;
		reg_rdata <= (rcnt == 4'h1) ? rd : ~reg_rdata;
	end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the aperture decoder
`timescale 1ns/100ps
module testbench;
	import ard_pkg::*;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic mm_reg_en = 1'h1;
	logic ap_4mb = 1'h0;
	logic req_valid = 1'h0;
	logic req_write = 1'h0;
	logic [21:0] req_addr = 22'h0;
	logic [31:0] req_wdata = 32'h0;
	logic [3:0] req_be = 4'h0;
	logic fb_rvalid, reg_rvalid, fb_req, fb_write, reg_rd, reg_wr, reg_ext, rsp_valid;
	logic [31:0] fb_rdata, fb_wdata, rsp_data;
	logic [21:0] fb_addr;
	logic [15:0] reg_rdata, reg_port, reg_wdata;
	logic [3:0] fb_be;
	logic [1:0] reg_be;
	int n_mismatch = 0;
	int num_checks = 0;
	always #2.5 mclk = ~mclk;
	ard_decoder i_dut (
		.mclk(mclk),
		.rst(rst),
		.mm_reg_en(mm_reg_en),
		.ap_4mb(ap_4mb),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_be(req_be),
		.fb_rvalid(fb_rvalid),
		.fb_rdata(fb_rdata),
		.reg_rvalid(reg_rvalid),
		.reg_rdata(reg_rdata),
		.fb_req(fb_req),
		.fb_write(fb_write),
		.fb_addr(fb_addr),
		.fb_wdata(fb_wdata),
		.fb_be(fb_be),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_ext(reg_ext),
		.reg_port(reg_port),
		.reg_wdata(reg_wdata),
		.reg_be(reg_be),
		.rsp_valid(rsp_valid),
		.rsp_data(rsp_data)
	);
	ard_resp i_resp (
		.mclk(mclk),
		.fb_req(fb_req),
		.fb_write(fb_write),
		.fb_addr(fb_addr),
		.reg_rd(reg_rd),
		.reg_port(reg_port),
		.fb_rvalid(fb_rvalid),
		.fb_rdata(fb_rdata),
		.reg_rvalid(reg_rvalid),
		.reg_rdata(reg_rdata)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// k: 0 dropped, 1 frame buffer, 2 register; entered just after an edge
	task automatic acc(input logic w, input logic [21:0] a, input logic [3:0] be, input int k);
		logic [15:0] p;
		int n;
		p = {a[7:2], a[8] ? 10'h2EE : 10'h2E8};
		req_valid = 1'h1;
		req_write = w;
		req_addr = a;
		req_wdata = {10'h3A5, a};
		req_be = be;
		@(posedge mclk) #1;
		req_valid = 1'h0;
		// strobes stand only in the cycle after the taking edge
		chk(fb_req, k == 1);
		chk(reg_rd, k == 2 && !w);
		chk(reg_wr, k == 2 && w);
		if (k == 1) begin
			chk(fb_addr, a);
			chk(fb_write, w);
			chk(fb_wdata, req_wdata);
			chk(fb_be, be);
		end
		if (k == 2) begin
			chk(reg_port, p);
			chk(reg_ext, a[8]);
			chk(reg_be, be[1:0]);
			if (w)
				chk(reg_wdata, req_wdata[15:0]);
		end
		if (!w && k != 0) begin
			for (n = 0; n < 20 && rsp_valid !== 1'h1; n++)
				@(posedge mclk) #1;
			chk(rsp_valid, 1'h1);
			chk(rsp_data, (k == 2) ? {16'h0000, p} : {10'h000, a});
		end
		@(posedge mclk) #1;
	endtask
	task automatic t_slots;
		acc(1'h0, 22'h0FFE00, 4'hF, 2);
		acc(1'h0, 22'h0FFE04, 4'hF, 2);
		acc(1'h0, 22'h0FFEFC, 4'hF, 2);
		acc(1'h0, 22'h0FFF00, 4'hF, 2);
		acc(1'h0, 22'h0FFFFC, 4'hF, 2);
	endtask
	task automatic t_write;
		acc(1'h1, 22'h0FFFFC, 4'hF, 2);
		acc(1'h1, 22'h0FFE00, 4'h1, 2);
		acc(1'h1, 22'h0FFE40, 4'hC, 0);
	endtask
	task automatic t_off;
		acc(1'h0, 22'h0FFDFC, 4'hF, 1);
		mm_reg_en = 1'h0;
		acc(1'h0, 22'h0FFE00, 4'hF, 1);
		acc(1'h1, 22'h0FFFFC, 4'hF, 1);
		mm_reg_en = 1'h1;
	endtask
	task automatic t_4mb;
		ap_4mb = 1'h1;
		acc(1'h0, 22'h3FFE00, 4'hF, 2);
		acc(1'h0, 22'h0FFE00, 4'hF, 1);
		acc(1'h1, 22'h3FFF04, 4'h3, 2);
		mm_reg_en = 1'h0;
		acc(1'h0, 22'h3FFFFC, 4'hF, 1);
		mm_reg_en = 1'h1;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		#1 rst = 1'h0;
		t_slots();
		t_write();
		t_off();
		t_4mb();
		end_sim();
	end
	// whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule
